// file: src/apc_cfg.svh
// apc_cfg.svh: field positions, reset values and timing counts of the
// converter power and setup control. definitions only.
`ifndef APC_CFG_SVH
`define APC_CFG_SVH

`define APC_WORD_W 16
`define APC_SEL_BIT 15
`define APC_SETUP_ID_HI 15
`define APC_SETUP_ID_LO 11
`define APC_SETUP_ID 5'h10
`define APC_REF_BIT 10
`define APC_AVG_ON_BIT 9
`define APC_AVG_CNT_HI 8
`define APC_AVG_CNT_LO 7
`define APC_STATIC_PWR_HI 4
`define APC_STATIC_PWR_LO 3
`define APC_AUTO_PWR_HI 3
`define APC_AUTO_PWR_LO 2
`define APC_SW_CONVERT_BIT 1
`define APC_REF_RST 1'b0
`define APC_AVG_ON_RST 1'b0
`define APC_AVG_CNT_RST 2'h0
`define APC_STATIC_PWR_RST 2'h0
`define APC_AUTO_PWR_RST 2'h0
`define APC_CLK_PERIOD_NS 10
`define APC_WAKE_CYCLES 2

`endif

// file: src/apc_pkg.sv
// apc_pkg.sv: types shared by the power and setup control.
// assumes apc_cfg.svh is on the include path.
package apc_pkg;
   typedef enum logic [1:0] {APC_PWR_NORMAL, APC_PWR_FULL, APC_PWR_BIAS, APC_PWR_RSVD} apc_pwr_e;
   typedef enum logic [1:0] {APC_ST_ON, APC_ST_DOWN, APC_ST_WAKE} apc_state_e;
   typedef logic [1:0] apc_pstate_t;
endpackage : apc_pkg

// file: src/apc_power_ctrl.sv
// apc_power_ctrl.sv: command word decode, setup fields and power management.
// assumes sclk stops outside frames, frames carry whole 16-bit words and
// the scan-mode decode supplies the clock mode and conversion-done pulse.
`timescale 1ns/1ps
`include "apc_cfg.svh"

module apc_power_ctrl #(
   parameter int WAKE_NS = `APC_WAKE_CYCLES * `APC_CLK_PERIOD_NS
) (
   input wire logic clk, // system clock, 100 MHz
   input wire logic rst, // synchronous, active high
   input wire logic sclk, // serial clock from host
   input wire logic csN, // chip select pin, active low
   input wire logic din, // serial data pin, msb first
   input wire logic convertStartN, // convert start pin, active low
   input wire logic clockModeInternal, // scan decode: internal clock mode
   input wire logic convDone, // pulse: all conversions of request done
   output apc_pkg::apc_pstate_t powerState, // 00 on, 01 full, 10 bias, 11 waking
   output logic resultValid, // conversions may be used
   output logic referenceChoice, // 1 differential reference
   output logic averagingEnable, // averaging field as written
   output logic [1:0] averageCount, // count field as written
   output logic [5:0] convPerResult // conversions per result
);
   import apc_pkg::*;

   localparam int WAKE_CYC = (WAKE_NS + `APC_CLK_PERIOD_NS - 1) / `APC_CLK_PERIOD_NS;
   localparam logic [2:0] WAKE_LAST = 3'(WAKE_CYC - 1);

   function automatic logic [5:0] conv_count(input logic averaging_enable_bit, input logic [1:0] cnt);
      if (!averaging_enable_bit) begin
         return 6'h01;
      end
      return 6'(6'h04 << cnt); // 4, 8, 16, 32
   endfunction : conv_count

   // ==========================================================
   // link side: shift in words on sclk
   // ==========================================================
   logic linkRstMeta, linkRst;
   logic [3:0] bitCnt, next_bitCnt;
   logic [14:0] shiftReg, next_shiftReg;
   logic [15:0] wordHold, next_wordHold;
   logic wordTgl, next_wordTgl;

   always_comb begin
      next_bitCnt = bitCnt;
      next_shiftReg = shiftReg;
      next_wordHold = wordHold;
      next_wordTgl = wordTgl;
      if (linkRst) begin
         next_bitCnt = 4'h0;
         next_wordTgl = 1'b0;
      end else if (!csN) begin
         next_bitCnt = bitCnt + 4'h1;
         next_shiftReg = {shiftReg[13:0], din};
         if (bitCnt == 4'hF) begin
            // held word stays stable for 16 sclk, far longer than the crossing
            next_wordHold = {shiftReg, din};
            next_wordTgl = ~wordTgl;
         end
      end
   end

   always_ff @(posedge sclk) begin
      linkRstMeta <= rst;
      linkRst <= linkRstMeta;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      wordHold <= next_wordHold;
      wordTgl <= next_wordTgl;
   end

   // ==========================================================
   // pin and word crossings into clk
   // ==========================================================
   logic tglMeta, tglSync, tglPrev;
   logic csMeta, csSync, csPrev;
   logic cnvMeta, cnvSync, cnvPrev;

   always_ff @(posedge clk) begin
      if (rst) begin
         tglMeta <= 1'b0;
         tglSync <= 1'b0;
         tglPrev <= 1'b0;
         csMeta <= 1'b1;
         csSync <= 1'b1;
         csPrev <= 1'b1;
         cnvMeta <= 1'b1;
         cnvSync <= 1'b1;
         cnvPrev <= 1'b1;
      end else begin
         tglMeta <= wordTgl;
         tglSync <= tglMeta;
         tglPrev <= tglSync;
         csMeta <= csN;
         csSync <= csMeta;
         csPrev <= csSync;
         cnvMeta <= convertStartN;
         cnvSync <= cnvMeta;
         cnvPrev <= cnvSync;
      end
   end

   logic newWord, csRise, csFall, cnvFall, modeWrite, setupWrite;
   assign newWord = tglSync ^ tglPrev;
   assign csRise = csSync & ~csPrev;
   assign csFall = ~csSync & csPrev;
   assign cnvFall = ~cnvSync & cnvPrev;
   assign modeWrite = newWord && !wordHold[`APC_SEL_BIT];
   assign setupWrite = newWord && wordHold[`APC_SETUP_ID_HI:`APC_SETUP_ID_LO] == `APC_SETUP_ID;

   // ==========================================================
   // setup fields, mode fields and power state
   // ==========================================================
   logic [1:0] staticPower, next_staticPower;
   logic [1:0] autoPower, next_autoPower;
   logic swcnvPending, next_swcnvPending;
   logic armed, next_armed;
   apc_state_e state, next_state;
   logic [2:0] wakeCnt, next_wakeCnt;
   logic next_referenceChoice, next_averagingEnable, next_resultValid;
   logic [1:0] next_averageCount;
   logic [5:0] next_convPerResult;
   apc_pstate_t next_powerState;
   logic autoOn;

   always_comb begin
      next_referenceChoice = referenceChoice;
      next_averagingEnable = averagingEnable;
      next_averageCount = averageCount;
      next_staticPower = staticPower;
      next_autoPower = autoPower;
      next_swcnvPending = swcnvPending;
      next_armed = armed;
      next_state = state;
      next_wakeCnt = wakeCnt;
      autoOn = (autoPower == APC_PWR_FULL) || (autoPower == APC_PWR_BIAS);
      // fields change only on writes, never on power transitions
      if (setupWrite) begin
         next_referenceChoice = wordHold[`APC_REF_BIT];
         next_averagingEnable = wordHold[`APC_AVG_ON_BIT];
         next_averageCount = wordHold[`APC_AVG_CNT_HI:`APC_AVG_CNT_LO];
         next_staticPower = wordHold[`APC_STATIC_PWR_HI:`APC_STATIC_PWR_LO];
      end
      unique case (state)
         APC_ST_ON: begin
            if (autoOn && clockModeInternal && convDone) begin
               next_state = APC_ST_DOWN;
            end else if (csRise) begin
               // the programming frame's own end only disarms
               next_armed = 1'b0;
               if (autoOn && !clockModeInternal && !armed && !modeWrite) begin
                  next_state = APC_ST_DOWN;
               end
            end
         end
         APC_ST_DOWN: begin
            if (!autoOn) begin
               next_state = APC_ST_WAKE;
            end else if (!clockModeInternal && csFall) begin
               next_state = APC_ST_WAKE;
            end else if (clockModeInternal && (cnvFall || (csRise && swcnvPending))) begin
               next_state = APC_ST_WAKE;
               next_swcnvPending = 1'b0;
            end
            next_wakeCnt = 3'h0;
            if (csRise) begin
               next_armed = 1'b0;
            end
         end
         APC_ST_WAKE: begin
            next_wakeCnt = wakeCnt + 3'h1;
            if (wakeCnt == WAKE_LAST) begin
               next_state = APC_ST_ON;
            end
         end
      endcase
      // after the case: a new mode word wins over a same-cycle clear
      if (modeWrite) begin
         next_autoPower = wordHold[`APC_AUTO_PWR_HI:`APC_AUTO_PWR_LO];
         next_swcnvPending = wordHold[`APC_SW_CONVERT_BIT];
         next_armed = 1'b1;
      end
      next_powerState = APC_PWR_NORMAL;
      if (staticPower == APC_PWR_FULL || staticPower == APC_PWR_BIAS) begin
         next_powerState = staticPower;
      end else if (state == APC_ST_DOWN) begin
         next_powerState = autoPower;
      end else if (state == APC_ST_WAKE) begin
         next_powerState = APC_PWR_RSVD;
      end
      next_resultValid = (next_powerState == APC_PWR_NORMAL);
      next_convPerResult = conv_count(averagingEnable && clockModeInternal, averageCount);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         referenceChoice <= `APC_REF_RST;
         averagingEnable <= `APC_AVG_ON_RST;
         averageCount <= `APC_AVG_CNT_RST;
         staticPower <= `APC_STATIC_PWR_RST;
         autoPower <= `APC_AUTO_PWR_RST;
         swcnvPending <= 1'b0;
         armed <= 1'b0;
         state <= APC_ST_ON;
         wakeCnt <= 3'h0;
         powerState <= APC_PWR_NORMAL;
         resultValid <= 1'b1;
         convPerResult <= 6'h01;
      end else begin
         referenceChoice <= next_referenceChoice;
         averagingEnable <= next_averagingEnable;
         averageCount <= next_averageCount;
         staticPower <= next_staticPower;
         autoPower <= next_autoPower;
         swcnvPending <= next_swcnvPending;
         armed <= next_armed;
         state <= next_state;
         wakeCnt <= next_wakeCnt;
         powerState <= next_powerState;
         resultValid <= next_resultValid;
         convPerResult <= next_convPerResult;
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   mode_write_route_a: assert property (modeWrite |=> autoPower == $past(wordHold[3:2]))
      else $error("mode word not routed to mode control");
   setup_write_fields_a: assert property (setupWrite |=> referenceChoice == $past(wordHold[10])
      && averageCount == $past(wordHold[8:7]))
      else $error("setup word fields not stored");
   setup_not_mode_a: assert property (setupWrite && !modeWrite |=> $stable(autoPower))
      else $error("setup word changed mode control");
   static_full_off_a: assert property (staticPower == 2'h1 |=> powerState == 2'h1 && !resultValid)
      else $error("static full shutdown not shown");
   normal_never_down_a: assert property (autoPower == 2'h0 && state == APC_ST_ON |=> state != APC_ST_DOWN)
      else $error("down with auto power off");
   wake_two_cycles_a: assert property ($rose(state == APC_ST_WAKE) |-> (state == APC_ST_WAKE)[*2]
      ##1 state == APC_ST_ON)
      else $error("wake period not two cycles");
   wake_suppress_a: assert property (state == APC_ST_WAKE |=> !resultValid)
      else $error("result valid while waking");
   ext_cs_wake_a: assert property (state == APC_ST_DOWN && autoOn && !clockModeInternal && csFall
      |=> state == APC_ST_WAKE)
      else $error("no wake on chip select fall");
   int_done_down_a: assert property (state == APC_ST_ON && autoOn && clockModeInternal && convDone
      |=> state == APC_ST_DOWN ##1 powerState == $past(autoPower) || staticPower != 2'h0)
      else $error("no power down after conversions");
   avg_off_one_a: assert property (!averagingEnable |=> convPerResult == 6'h01)
      else $error("averaging off but not one conversion");
   avg_four_a: assert property (averagingEnable && clockModeInternal && averageCount == 2'h0
      |=> convPerResult == 6'h04)
      else $error("count 00 not four conversions");
   avg_eight_a: assert property (averagingEnable && clockModeInternal && averageCount == 2'h1
      |=> convPerResult == 6'h08)
      else $error("count 01 not eight conversions");
   avg_sixteen_a: assert property (averagingEnable && clockModeInternal && averageCount == 2'h2
      |=> convPerResult == 6'h10)
      else $error("count 10 not sixteen conversions");
   avg_max_count_a: assert property (averagingEnable && clockModeInternal && averageCount == 2'h3
      |=> convPerResult == 6'h20)
      else $error("count 11 not thirty-two conversions");
   ext_avg_single_a: assert property (!clockModeInternal |=> convPerResult == 6'h01)
      else $error("averaging applied in external clock mode");
   partial_bias_keep_a: assert property (staticPower == 2'h2 |=> powerState == 2'h2 && !resultValid)
      else $error("static partial shutdown not shown");
   ext_frame_down_a: assert property (state == APC_ST_ON && autoOn && !clockModeInternal && csRise
      && !armed && !modeWrite |=> state == APC_ST_DOWN)
      else $error("no power down at end of next frame");
   int_start_wake_a: assert property (state == APC_ST_DOWN && autoOn && clockModeInternal
      && cnvFall |=> state == APC_ST_WAKE)
      else $error("no wake on convert start fall");
   fields_kept_a: assert property (!setupWrite |=> $stable(referenceChoice)
      && $stable(averagingEnable) && $stable(averageCount))
      else $error("setup fields changed without a write");
endmodule : apc_power_ctrl

// file: bench/apc_host_model.sv
// apc_host_model.sv: behavioural serial host driving the setup link.
// assumes the bench calls one task at a time; sclk idles low between frames.
`timescale 1ns/1ps

module apc_host_model (
   output logic sclk, // serial clock, runs inside frames and during idleClocks with cs high
   output logic csN, // chip select, active low
   output logic din // serial data, msb first
);
   initial begin
      sclk = 1'h0;
      csN = 1'h1;
      din = 1'h0;
   end

   // ==========================================
   // link tasks
   // edges with cs high, only so the link reset sync can settle
   task automatic idleClocks(input int n);
      repeat (n) begin
         #40 sclk = 1'h1;
         #40 sclk = 1'h0;
      end
   endtask : idleClocks

   // no delay: the bench must catch the short wake window itself
   task automatic select(input logic lvl);
      csN = lvl;
   endtask : select

   task automatic sendWord(input logic [15:0] w);
      // cs high gap first, so a frame right after another shows both cs edges
      #80 csN = 1'h0;
      for (int i = 15; i >= 0; i--) begin
         din = w[i];
         #40 sclk = 1'h1;
         #40 sclk = 1'h0;
      end
      #40 csN = 1'h1;
      din = ~din; // after release din drives the inverted last bit, no stale bit
   endtask : sendWord
endmodule : apc_host_model

// file: bench/adc_power_config_control_test.sv
// adc_power_config_control_test.sv: self-checking bench of the power control.
// assumes apc_pkg and apc_cfg.svh compiled first; host model drives the link.
`timescale 1ns/1ps

module adc_power_config_control_test;
   import apc_pkg::*;
   logic clk = 1'h0;
   logic rst;
   logic convertStartN;
   logic clockModeInternal;
   logic convDone;
   logic sclk, csN, din, resultValid, referenceChoice, averagingEnable;
   apc_pstate_t powerState;
   logic [1:0] averageCount, ex;
   logic [5:0] convPerResult;
   int mismatches = 0;
   int compares = 0;
   logic ref0 = 1'h0;
   logic avg0 = 1'h0;
   logic [1:0] cnt0 = 2'h0;

   always #5 clk = ~clk;

   apc_host_model apc_host_model_i (.sclk(sclk), .csN(csN), .din(din));
   apc_power_ctrl apc_power_ctrl_i (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .din(din),
      .convertStartN(convertStartN), .clockModeInternal(clockModeInternal), .convDone(convDone),
      .powerState(powerState), .resultValid(resultValid), .referenceChoice(referenceChoice),
      .averagingEnable(averagingEnable), .averageCount(averageCount),
      .convPerResult(convPerResult));

   // ==========================================
   // helpers
   function automatic logic [5:0] expConv(logic on, logic [1:0] c, logic intl);
      return (on && intl) ? 6'(4 << c) : 6'h01;
   endfunction : expConv

   task automatic summarize();
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic checkFields();
      check(16'({referenceChoice, averagingEnable, averageCount}), 16'({ref0, avg0, cnt0}));
   endtask : checkFields

   task automatic settle();
      repeat (10) @(posedge clk);
      #1;
   endtask : settle

   task automatic writeCfg(input logic [1:0] static_power_field);
      apc_host_model_i.sendWord({5'h10, ref0, avg0, cnt0, 2'h0, static_power_field, 3'h0});
      settle();
   endtask : writeCfg

   task automatic waitPs(input apc_pstate_t e);
      int n;
      n = 0;
      while (powerState !== e) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 60) begin
            check(16'(powerState), 16'(e));
            summarize();
         end
      end
   endtask : waitPs

   // waking must last exactly two cycles with results held back
   task automatic checkWake();
      waitPs(2'h3);
      @(posedge clk);
      #1;
      check(16'({powerState, resultValid}), 16'h6);
      @(posedge clk);
      #1;
      check(16'({powerState, resultValid}), 16'h1);
   endtask : checkWake

   task automatic pulseDone();
      @(posedge clk);
      convDone <= 1'h1;
      @(posedge clk);
      convDone <= 1'h0;
   endtask : pulseDone

   // ==========================================
   // main sequence
   initial begin
      rst <= 1'h1;
      convertStartN <= 1'h1;
      clockModeInternal <= 1'h0;
      convDone <= 1'h0;
      void'($urandom(81035));
      // sclk keeps running after release until the link reset sync has passed
      fork
         apc_host_model_i.idleClocks(4);
         begin
            repeat (16) @(posedge clk);
            rst <= 1'h0;
         end
      join
      settle();
      check(16'({powerState, resultValid}), 16'h1);
      checkFields();
      check(16'(convPerResult), 16'h1);
      for (int i = 0; i < 16; i++) begin
         ref0 = 1'($urandom);
         avg0 = (i < 4) | 1'($urandom);
         cnt0 = (i < 4) ? 2'(i) : 2'($urandom);
         @(posedge clk);
         clockModeInternal <= (i < 4) | 1'($urandom);
         writeCfg(2'h0);
         checkFields();
         check(16'(convPerResult), 16'(expConv(avg0, cnt0, clockModeInternal)));
         apc_host_model_i.sendWord({1'h1, 4'(1 + $urandom % 15), 11'($urandom)});
         settle();
         checkFields();
      end
      for (int s = 1; s < 4; s++) begin
         writeCfg(2'(s));
         check(16'(powerState), (s == 3) ? 16'h0 : 16'(s));
         checkFields();
      end
      writeCfg(2'h0);
      @(posedge clk);
      clockModeInternal <= 1'h0;
      for (int pm = 0; pm < 4; pm++) begin
         ex = (pm == 3) ? 2'h0 : 2'(pm);
         apc_host_model_i.sendWord({12'h000, 2'(pm), 2'h0});
         writeCfg(2'h0);
         check(16'({powerState, resultValid}), 16'({ex, ex == 2'h0}));
         checkFields();
         if (ex != 2'h0) begin
            apc_host_model_i.select(1'h0);
            checkWake();
            apc_host_model_i.select(1'h1);
            waitPs(ex);
            apc_host_model_i.sendWord(16'h0000);
            settle();
         end
      end
      @(posedge clk);
      clockModeInternal <= 1'h1;
      apc_host_model_i.sendWord(16'h0004);
      settle();
      pulseDone();
      waitPs(2'h1);
      @(posedge clk);
      convertStartN <= 1'h0;
      checkWake();
      convertStartN <= 1'h1;
      apc_host_model_i.sendWord(16'h000A);
      settle();
      pulseDone();
      waitPs(2'h2);
      apc_host_model_i.sendWord({5'h10, ref0, avg0, cnt0, 7'h00});
      checkWake();
      checkFields();
      summarize();
   end
endmodule : adc_power_config_control_test
